/* File: core/accel_pkg.sv */
// package of constants shared by the sample output register bank
// assumes 8-bit register addresses and 10-bit two's-complement samples
package accel_pkg;

    // sample layout
    localparam int         SAMPLE_W  = 10;
    localparam int         AXES      = 3;
    localparam int         LOW_PAD_W = 6;

    // register addresses
    localparam logic [7:0] ADDR_STATUS        = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH        = 8'h01;
    localparam logic [7:0] ADDR_X_LOW         = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH        = 8'h03;
    localparam logic [7:0] ADDR_Y_LOW         = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH        = 8'h05;
    localparam logic [7:0] ADDR_Z_LOW         = 8'h06;
    localparam logic [7:0] ADDR_FIRST_CONTROL = 8'h2a;
    localparam int         FAST_READ_BIT      = 1;

    // data_status field positions
    localparam int         ALL_OW_BIT    = 7;
    localparam int         Z_OW_BIT      = 6;
    localparam int         Y_OW_BIT      = 5;
    localparam int         X_OW_BIT      = 4;
    localparam int         ALL_READY_BIT = 3;
    localparam int         Z_READY_BIT   = 2;
    localparam int         Y_READY_BIT   = 1;
    localparam int         X_READY_BIT   = 0;

    // reset values
    localparam logic [7:0]          STATUS_RESET = 8'h00;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 10'h000;
    localparam logic [7:0]          BYTE_RESET   = 8'h00;

    // crossing word widths: status, three samples, three tags / mask plus tags
    localparam int         SNAP_W  = 8 + AXES * SAMPLE_W + AXES;
    localparam int         EVENT_W = 2 * AXES;

endpackage : accel_pkg

/* File: core/accel_sample_output_regs.sv */
// sample output register bank: data status plus three 10-bit axis samples
// assumes samples and control levels arrive on sys_clk; register reads come
// from a serial engine clocked by link_clk
module accel_sample_output_regs (
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    input  wire logic                          active_mode,
    input  wire logic                          fast_read,
    input  wire logic [accel_pkg::AXES-1:0]    sample_valid,
    input  wire logic [accel_pkg::SAMPLE_W-1:0] x_sample,
    input  wire logic [accel_pkg::SAMPLE_W-1:0] y_sample,
    input  wire logic [accel_pkg::SAMPLE_W-1:0] z_sample,
    output logic      [7:0]                    data_status,
    input  wire logic                          link_clk,
    input  wire logic                          link_rd_start,
    input  wire logic [7:0]                    link_rd_addr,
    input  wire logic                          link_rd_next,
    output logic      [7:0]                    link_rdata
);

    // address step of the auto-increment, with or without fast read
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
        logic [7:0] n;
        n = a + 8'h01;
        if (fast && (a == accel_pkg::ADDR_X_HIGH || a == accel_pkg::ADDR_Y_HIGH))
            n = a + 8'h02;
        if (a == accel_pkg::ADDR_Z_LOW || (fast && a == accel_pkg::ADDR_Z_HIGH))
            n = accel_pkg::ADDR_STATUS;
        return n;
    endfunction : next_addr

    // ---------------- sys_clk domain ----------------
    logic [accel_pkg::AXES-1:0]     ready_q;
    logic [accel_pkg::AXES-1:0]     ow_q;
    logic [accel_pkg::AXES-1:0]     seen_q;
    logic [accel_pkg::AXES-1:0]     tag_q;
    logic                           all_ready_q;
    logic                           all_ow_q;
    logic                           active_prev_q;
    logic [accel_pkg::SAMPLE_W-1:0] x_q;
    logic [accel_pkg::SAMPLE_W-1:0] y_q;
    logic [accel_pkg::SAMPLE_W-1:0] z_q;
    logic [7:0]                     status_w;

    logic                           ev_valid;
    logic [accel_pkg::EVENT_W-1:0]  ev_data;
    logic                           snap_busy;

    // decoded read events coming back from the link side
    wire  [accel_pkg::AXES-1:0] ev_mask_w = ev_data[accel_pkg::AXES-1:0];
    wire  [accel_pkg::AXES-1:0] ev_tag_w  = ev_data[accel_pkg::EVENT_W-1:accel_pkg::AXES];

    // samples are taken only in active mode
    // standby gating
    wire  act_rise_w = active_mode & ~active_prev_q;
    wire  [accel_pkg::AXES-1:0] new_w = active_mode ? sample_valid : '0;

    // a clear counts only for the sample the host actually saw
    // set beats clear
    wire  [accel_pkg::AXES-1:0] clr_w = {accel_pkg::AXES{ev_valid}} & ev_mask_w & ~(ev_tag_w ^ tag_q) & ~new_w;
    wire  [accel_pkg::AXES-1:0] over_w = new_w & ready_q;
    wire  [accel_pkg::AXES-1:0] seen_w = (seen_q | clr_w) & ~new_w;
    wire  all_read_w = &seen_w;

    // per-axis flags
    // axis ready set
    wire  [accel_pkg::AXES-1:0] ready_d = (ready_q & ~clr_w) | new_w;
    wire  [accel_pkg::AXES-1:0] ow_d    = (ow_q & ~clr_w) | over_w;

    // combined flags
    // combined ready set
    wire  all_ready_d = (|new_w) | (all_ready_q & ~all_read_w);
    wire  all_ow_d    = (|over_w) | (all_ow_q & ~all_read_w);

    // status byte assembled by field position
    // live status byte
    always_comb
    begin
        status_w                           = accel_pkg::STATUS_RESET;
        status_w[accel_pkg::ALL_OW_BIT]    = all_ow_q;
        status_w[accel_pkg::Z_OW_BIT]      = ow_q[2];
        status_w[accel_pkg::Y_OW_BIT]      = ow_q[1];
        status_w[accel_pkg::X_OW_BIT]      = ow_q[0];
        status_w[accel_pkg::ALL_READY_BIT] = all_ready_q;
        status_w[accel_pkg::Z_READY_BIT]   = ready_q[2];
        status_w[accel_pkg::Y_READY_BIT]   = ready_q[1];
        status_w[accel_pkg::X_READY_BIT]   = ready_q[0];
    end

    // flag state; entering active mode starts clean
    // flags reset zero
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ready_q     <= '0;
            ow_q        <= '0;
            seen_q      <= '0;
            all_ready_q <= 1'b0;
            all_ow_q    <= 1'b0;
        end
        else if (ce && act_rise_w)
        begin
            ready_q     <= new_w;
            ow_q        <= '0;
            seen_q      <= '0;
            all_ready_q <= |new_w;
            all_ow_q    <= 1'b0;
        end
        else if (ce)
        begin
            ready_q     <= ready_d;
            ow_q        <= ow_d;
            // seen bits stay set until a newer sample on that axis
            seen_q      <= seen_w;
            all_ready_q <= all_ready_d;
            all_ow_q    <= all_ow_d;
        end
    end

    // sample store, generation tags and the status output
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            x_q           <= accel_pkg::SAMPLE_RESET;
            y_q           <= accel_pkg::SAMPLE_RESET;
            z_q           <= accel_pkg::SAMPLE_RESET;
            tag_q         <= '0;
            active_prev_q <= 1'b0;
            data_status   <= accel_pkg::STATUS_RESET;
        end
        else if (ce)
        begin
            if (new_w[0])
                x_q <= x_sample;
            if (new_w[1])
                y_q <= y_sample;
            if (new_w[2])
                z_q <= z_sample;
            tag_q         <= tag_q ^ new_w;
            active_prev_q <= active_mode;
            data_status   <= status_w;
        end
    end

    // ---------------- crossings ----------------
    logic                          link_rst_n;
    logic                          link_ce;
    logic                          link_fast;
    logic                          snap_valid;
    logic [accel_pkg::SNAP_W-1:0]  snap_q;
    logic                          ev_busy;
    logic [accel_pkg::AXES-1:0]    pend_q;
    logic [accel_pkg::AXES-1:0]    pend_tag_q;

    bit_sync #(.W(1)) u_rst_sync (
        .clk   (link_clk),
        .rst_n (1'b1),
        .d     (nrst),
        .q     (link_rst_n)
    );

    bit_sync #(.W(2)) u_ctl_sync (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .d     ({fast_read, ce}),
        .q     ({link_fast, link_ce})
    );

    // status, samples and tags are resent as one coherent word
    sample_cdc #(.W(accel_pkg::SNAP_W)) u_snap_cdc (
        .src_clk   (sys_clk),
        .src_rst_n (nrst),
        .src_ce    (ce),
        .src_load  (1'b1),
        .src_data  ({status_w, z_q, y_q, x_q, tag_q}),
        .src_busy  (snap_busy),
        .dst_clk   (link_clk),
        .dst_rst_n (link_rst_n),
        .dst_ce    (link_ce),
        .dst_valid (snap_valid),
        .dst_data  (snap_q)
    );

    // high byte reads travel back as a mask with the tags seen
    sample_cdc #(.W(accel_pkg::EVENT_W)) u_event_cdc (
        .src_clk   (link_clk),
        .src_rst_n (link_rst_n),
        .src_ce    (link_ce),
        .src_load  (|pend_q),
        .src_data  ({pend_tag_q, pend_q}),
        .src_busy  (ev_busy),
        .dst_clk   (sys_clk),
        .dst_rst_n (nrst),
        .dst_ce    (ce),
        .dst_valid (ev_valid),
        .dst_data  (ev_data)
    );

    // ---------------- link_clk domain ----------------
    logic [7:0]                 ptr_q;
    logic [1:0]                 hold_x_q;
    logic [1:0]                 hold_y_q;
    logic [1:0]                 hold_z_q;

    // snapshot fields
    wire  [accel_pkg::AXES-1:0]     s_tag_w = snap_q[accel_pkg::AXES-1:0];
    wire  [accel_pkg::SAMPLE_W-1:0] s_x_w   = snap_q[accel_pkg::AXES +: accel_pkg::SAMPLE_W];
    wire  [accel_pkg::SAMPLE_W-1:0] s_y_w   = snap_q[accel_pkg::AXES + accel_pkg::SAMPLE_W +: accel_pkg::SAMPLE_W];
    wire  [accel_pkg::SAMPLE_W-1:0] s_z_w   = snap_q[accel_pkg::AXES + 2 * accel_pkg::SAMPLE_W +: accel_pkg::SAMPLE_W];
    wire  [7:0]                     s_st_w  = snap_q[accel_pkg::SNAP_W-1 -: 8];

    // address of the byte handed out this cycle
    // auto-increment, skipping low bytes in fast read
    wire  rd_w = link_ce && (link_rd_start || link_rd_next);
    wire  [7:0] addr_w = link_rd_start ? link_rd_addr : next_addr(ptr_q, link_fast);
    wire  [accel_pkg::AXES-1:0] high_w = {rd_w && addr_w == accel_pkg::ADDR_Z_HIGH,
                                          rd_w && addr_w == accel_pkg::ADDR_Y_HIGH,
                                          rd_w && addr_w == accel_pkg::ADDR_X_HIGH};

    // byte select; low bytes come from the hold of the last high read
    // byte layout
    wire  [5:0] pad_w = 6'h00;
    wire  [7:0] byte_w =
        (addr_w == accel_pkg::ADDR_STATUS) ? s_st_w :
        (addr_w == accel_pkg::ADDR_X_HIGH) ? s_x_w[accel_pkg::SAMPLE_W-1:2] :
        (addr_w == accel_pkg::ADDR_X_LOW)  ? {hold_x_q, pad_w} :
        (addr_w == accel_pkg::ADDR_Y_HIGH) ? s_y_w[accel_pkg::SAMPLE_W-1:2] :
        (addr_w == accel_pkg::ADDR_Y_LOW)  ? {hold_y_q, pad_w} :
        (addr_w == accel_pkg::ADDR_Z_HIGH) ? s_z_w[accel_pkg::SAMPLE_W-1:2] :
        (addr_w == accel_pkg::ADDR_Z_LOW)  ? {hold_z_q, pad_w} :
                                             accel_pkg::BYTE_RESET;

    // pointer, read data and low bit holds
    // same-sample pair
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            ptr_q      <= accel_pkg::ADDR_STATUS;
            link_rdata <= accel_pkg::BYTE_RESET;
            hold_x_q   <= 2'h0;
            hold_y_q   <= 2'h0;
            hold_z_q   <= 2'h0;
        end
        else if (rd_w)
        begin
            ptr_q      <= addr_w;
            link_rdata <= byte_w;
            if (high_w[0])
                hold_x_q <= s_x_w[1:0];
            if (high_w[1])
                hold_y_q <= s_y_w[1:0];
            if (high_w[2])
                hold_z_q <= s_z_w[1:0];
        end
    end

    // pending high reads wait until the crossing is free
    // high read report
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            pend_q     <= '0;
            pend_tag_q <= '0;
        end
        else if (link_ce)
        begin
            pend_q     <= (ev_busy ? pend_q : '0) | high_w;
            pend_tag_q <= (pend_tag_q & ~high_w) | (s_tag_w & high_w);
        end
    end

endmodule : accel_sample_output_regs

/* File: core/bit_sync.sv */
// two flip-flop level synchroniser
// assumes d comes from another clock domain or a pin
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : bit_sync

/* File: core/sample_cdc.sv */
// word crossing by toggle request and acknowledge
// assumes src_data is sampled only on a load taken while not busy
module sample_cdc #(
    parameter int W = 8
) (
    input  wire logic         src_clk,
    input  wire logic         src_rst_n,
    input  wire logic         src_ce,
    input  wire logic         src_load,
    input  wire logic [W-1:0] src_data,
    output logic              src_busy,
    input  wire logic         dst_clk,
    input  wire logic         dst_rst_n,
    input  wire logic         dst_ce,
    output logic              dst_valid,
    output logic      [W-1:0] dst_data
);

    logic [W-1:0] data_q;
    logic         req_q;
    logic         ack_q;
    logic         req_s;
    logic         ack_s;
    wire          take_w = req_s ^ ack_q;

    // held word and request toggle on the source side
    always_ff @(posedge src_clk)
    begin
        if (!src_rst_n)
        begin
            data_q <= '0;
            req_q  <= 1'b0;
        end
        else if (src_ce && src_load && !src_busy)
        begin
            data_q <= src_data;
            req_q  <= ~req_q;
        end
    end

    assign src_busy = req_q ^ ack_s;

    bit_sync #(.W(1)) u_req_sync (
        .clk   (dst_clk),
        .rst_n (dst_rst_n),
        .d     (req_q),
        .q     (req_s)
    );

    bit_sync #(.W(1)) u_ack_sync (
        .clk   (src_clk),
        .rst_n (src_rst_n),
        .d     (ack_q),
        .q     (ack_s)
    );

    // capture the stable word and answer
    always_ff @(posedge dst_clk)
    begin
        if (!dst_rst_n)
        begin
            dst_valid <= 1'b0;
            dst_data  <= '0;
            ack_q     <= 1'b0;
        end
        else if (dst_ce)
        begin
            dst_valid <= take_w;
            if (take_w)
            begin
                dst_data <= data_q;
                ack_q    <= req_s;
            end
        end
    end

endmodule : sample_cdc

/* File: sim/host_reader.sv */
// host model issuing register read bursts on the link side
// assumes link_rdata is valid from the edge that takes a request
module host_reader (
    input  wire logic       link_clk,
    output logic            link_rd_start,
    output logic      [7:0] link_rd_addr,
    output logic            link_rd_next,
    input  wire logic [7:0] link_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rb [8];

    // idle request lines
    initial
    begin
        link_rd_start = 1'b0;
        link_rd_addr  = 8'h00;
        link_rd_next  = 1'b0;
    end

    task automatic burst(input logic [7:0] a, input int n, input int gap);
        @(posedge link_clk);
        link_rd_start <= 1'b1;
        link_rd_addr  <= a;
        for (int i = 0; i < n; i++)
        begin
            @(posedge link_clk);
            link_rd_start <= 1'b0;
            link_rd_next  <= (i < n - 1) && (gap == 0);
            link_rd_addr  <= ~a;
            #1 rb[i] = link_rdata;
            if (i < n - 1 && gap > 0)
            begin
                repeat (gap) @(posedge link_clk);
                link_rd_next <= 1'b1;
            end
        end
    endtask : burst
endmodule : host_reader

/* File: sim/out_regs_sva.sv */
// checker on the sample output register bank ports
// assumes bind to the bank; both domains reset through nrst
module out_regs_sva (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       ce,
    input wire logic       active_mode,
    input wire logic       fast_read,
    input wire logic [2:0] sample_valid,
    input wire logic [7:0] data_status,
    input wire logic       link_clk,
    input wire logic       link_rd_start,
    input wire logic [7:0] link_rd_addr,
    input wire logic       link_rd_next,
    input wire logic [7:0] link_rdata
);
    // sample is taken only while enabled and active
    wire take_ok = ce && active_mode;

    property p_x_ready;
        @(posedge sys_clk) disable iff (!nrst) take_ok && sample_valid[0] |-> ##2 data_status[0];
    endproperty
    a_x_ready: assert property (p_x_ready) else $error("x ready missing");
    property p_any_ready;
        @(posedge sys_clk) disable iff (!nrst) take_ok && |sample_valid |-> ##2 data_status[3];
    endproperty
    a_any_ready: assert property (p_any_ready) else $error("combined ready missing");
    property p_overwrite;
        @(posedge sys_clk) disable iff (!nrst)
        take_ok && sample_valid[0] ##1 take_ok && sample_valid[0] |-> ##2 data_status[4] && data_status[7];
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("overwrite flags missing");
    property p_reset_zero;
        @(posedge sys_clk) disable iff (!nrst) $rose(nrst) |-> data_status == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not zero");
    property p_standby;
        @(posedge sys_clk) disable iff (!nrst) !active_mode [*3] |-> !$rose(data_status[3]);
    endproperty
    a_standby: assert property (p_standby) else $error("flag set in standby");
    property p_ready_comb;
        @(posedge sys_clk) disable iff (!nrst) |data_status[2:0] |-> data_status[3];
    endproperty
    a_ready_comb: assert property (p_ready_comb) else $error("combined ready early clear");
    property p_unmapped;
        @(posedge link_clk) disable iff (!nrst) ce && link_rd_start && link_rd_addr > 8'h06 |=> link_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped byte not zero");
    property p_low_pad;
        @(posedge link_clk) disable iff (!nrst)
        ce && !fast_read && link_rd_start && link_rd_addr == 8'h01 ##1 link_rd_next |=> link_rdata[5:0] == 6'h00;
    endproperty
    a_low_pad: assert property (p_low_pad) else $error("low byte padding wrong");

    // main scenarios reached
    c_all_ow: cover property (@(posedge sys_clk) data_status == 8'hff);
    c_fast: cover property (@(posedge link_clk) fast_read && link_rd_next);
    c_standby: cover property (@(posedge sys_clk) !active_mode && data_status[1]);
endmodule : out_regs_sva

bind accel_sample_output_regs out_regs_sva chk_u (
    .sys_clk, .nrst, .ce, .active_mode, .fast_read, .sample_valid, .data_status,
    .link_clk, .link_rd_start, .link_rd_addr, .link_rd_next, .link_rdata
);

/* File: sim/tb.sv */
// bench: samples on sys_clk, register reads through the host model
// assumes the bank, its checker and the host model are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk      = 1'b0;
    logic       link_clk     = 1'b0;
    logic       nrst         = 1'b0;
    logic       ce           = 1'b1;
    logic       active_mode  = 1'b1;
    logic       fast_read    = 1'b0;
    logic [2:0] sample_valid = 3'h0;
    logic [9:0] x_sample     = 10'h000;
    logic [9:0] y_sample     = 10'h000;
    logic [9:0] z_sample     = 10'h000;
    logic [9:0] xv           = 10'h2a5;
    logic [9:0] yv           = 10'h0f3;
    logic [9:0] zv           = 10'h3fe;
    logic [7:0] bad [3]      = '{8'h07, 8'h2a, 8'hff};
    logic [7:0] data_status;
    logic       link_rd_start;
    logic [7:0] link_rd_addr;
    logic       link_rd_next;
    logic [7:0] link_rdata;
    int         n_errors     = 0;
    int         compares     = 0;
    int         cycles       = 0;

    // clocks, link edges never meet sys rising edges
    always #4 sys_clk = ~sys_clk;
    always #80 link_clk = ~link_clk;

    accel_sample_output_regs dut_u (
        .sys_clk, .nrst, .ce, .active_mode, .fast_read, .sample_valid, .x_sample, .y_sample,
        .z_sample, .data_status, .link_clk, .link_rd_start, .link_rd_addr, .link_rd_next, .link_rdata
    );
    host_reader host_u (.link_clk, .link_rd_start, .link_rd_addr, .link_rd_next, .link_rdata);

    // expected byte layout of a sample
    function automatic logic [7:0] hi(input logic [9:0] v);
        return v[9:2];
    endfunction : hi
    function automatic logic [7:0] lo(input logic [9:0] v);
        return {v[1:0], 6'h00};
    endfunction : lo

    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic lwait(input int k);
        repeat (k) @(posedge link_clk);
    endtask : lwait

    // one sample pulse held n cycles
    task automatic push(input logic [2:0] m, input int n);
        @(posedge sys_clk);
        sample_valid <= m;
        x_sample     <= xv;
        y_sample     <= yv;
        z_sample     <= zv;
        repeat (n) @(posedge sys_clk);
        sample_valid <= 3'h0;
    endtask : push

    // read with settling room for snapshot and flag clear
    task automatic rd(input logic [7:0] a, input int n, input int gap);
        lwait(10);
        host_u.burst(a, n, gap);
        lwait(10);
    endtask : rd

    task automatic chk_burst(input int n, input logic fr, input int s, input logic [7:0] st);
        logic [7:0] e [7];
        e = '{st, hi(xv), lo(xv), hi(yv), lo(yv), hi(zv), lo(zv)};
        for (int i = 0; i < n; i++)
            chk(host_u.rb[i], e[fr ? ((i == 0) ? 0 : 2 * i - 1) : s + i]);
    endtask : chk_burst

    // cut a hang short
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // main sequence; reset spans 8 link cycles so both domains see it
    initial
    begin
        repeat (8) @(posedge link_clk);
        @(posedge sys_clk);
        nrst <= 1'b1;
        tick(1);
        chk(data_status, 8'h00);
        push(3'h1, 1);
        tick(2);
        chk(data_status, 8'h09);
        push(3'h1, 2);
        tick(2);
        chk(data_status, 8'h99);
        push(3'h6, 1);
        tick(2);
        chk(data_status, 8'h9f);
        rd(8'h00, 7, 0);
        chk_burst(7, 1'b0, 0, 8'h9f);
        tick(1);
        chk(data_status, 8'h00);
        push(3'h7, 2);
        tick(2);
        chk(data_status, 8'hff);
        rd(8'h01, 3, 0);
        chk_burst(3, 1'b0, 1, 8'h00);
        tick(1);
        chk(data_status, 8'hcc);
        rd(8'h05, 1, 0);
        chk_burst(1, 1'b0, 5, 8'h00);
        tick(1);
        chk(data_status, 8'h00);
        @(posedge sys_clk);
        fast_read <= 1'b1;
        push(3'h7, 1);
        rd(8'h00, 4, 0);
        chk_burst(4, 1'b1, 0, 8'h0f);
        tick(1);
        chk(data_status, 8'h00);
        @(posedge sys_clk);
        fast_read <= 1'b0;
        push(3'h1, 1);
        // slow host, newer x sample lands between high and low
        fork
            rd(8'h01, 2, 12);
            begin
                lwait(14);
                xv = 10'h156;
                push(3'h1, 1);
            end
        join
        chk(host_u.rb[0], hi(10'h2a5));
        chk(host_u.rb[1], lo(10'h2a5));
        rd(8'h01, 1, 0);
        chk(host_u.rb[0], hi(10'h156));
        tick(1);
        chk(data_status, 8'h00);
        push(3'h2, 1);
        tick(2);
        chk(data_status, 8'h0a);
        @(posedge sys_clk);
        active_mode <= 1'b0;
        push(3'h7, 1);
        tick(3);
        chk(data_status, 8'h0a);
        @(posedge sys_clk);
        active_mode <= 1'b1;
        tick(3);
        chk(data_status, 8'h00);
        // frozen clock enable takes no sample
        @(posedge sys_clk);
        ce <= 1'b0;
        push(3'h4, 1);
        tick(3);
        chk(data_status, 8'h00);
        @(posedge sys_clk);
        ce <= 1'b1;
        tick(3);
        chk(data_status, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            rd(bad[i], 1, 0);
            chk(host_u.rb[0], 8'h00);
        end
        report_and_stop();
    end
endmodule : tb
